// ==== logic/sensor_link_pkg.sv ====
// Constants and carrier types for the single-wire sensor read link
// How it works
// - After power-up interval, take one measurement, store it, then sleep.
// - Idle sensor keeps pin as input and watches for low pulse.
// - Sensor answers low 80 us then high 80 us once released.
// - After response, sensor shifts out exactly forty data bits.
// - Zero bit is 50 us low then about 26 us high.
// - One bit is 50 us low then 70 us high.
// - After fortieth bit, drive low 50 us more, then release line.
// - After each transfer, take new measurement, store it, sleep again.
// - Only a host start pulse wakes the sensor from sleep.
// - Bits go MSB first: humidity high, low, temperature high, low, check.
// - Check byte is low eight bits of sum of four data bytes.
// - Values scaled by ten; temperature bit 15 is the sign flag.
package sensor_link_pkg;

	// ****************************************
	// Timing in microseconds (power-up in milliseconds) and in cycles
	// ****************************************
	localparam int CLK_MHZ        = 40;
	localparam int T_POWERUP_MS   = 2000;
	localparam int T_START_US     = 800;
	localparam int T_RESP_LOW_US  = 80;
	localparam int T_RESP_HIGH_US = 80;
	localparam int T_BIT_LOW_US   = 50;
	localparam int T_BIT0_HIGH_US = 26;
	localparam int T_BIT1_HIGH_US = 70;
	localparam int T_END_LOW_US   = 50;
	localparam int T_MEAS_US      = 100;

	localparam int CYC_START     = T_START_US * CLK_MHZ;
	localparam int CYC_RESP_LOW  = T_RESP_LOW_US * CLK_MHZ;
	localparam int CYC_RESP_HIGH = T_RESP_HIGH_US * CLK_MHZ;
	localparam int CYC_BIT_LOW   = T_BIT_LOW_US * CLK_MHZ;
	localparam int CYC_BIT0_HIGH = T_BIT0_HIGH_US * CLK_MHZ;
	localparam int CYC_BIT1_HIGH = T_BIT1_HIGH_US * CLK_MHZ;
	localparam int CYC_END_LOW   = T_END_LOW_US * CLK_MHZ;
	localparam int CYC_MEAS      = T_MEAS_US * CLK_MHZ;
	localparam int CYC_POWERUP   = T_POWERUP_MS * 1000 * CLK_MHZ;

	localparam int FRAME_BITS = 40;
	localparam int CNT_W      = 27;
	localparam int BIT_W      = 6;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic [15:0] humidity;
		logic        temp_neg;
		logic [14:0] temp_mag;
	} sample_t;

	typedef struct packed {
		logic        oe;
		logic        out;
	} pin_drive_t;

	typedef enum logic [3:0] {
		ST_POWERUP, ST_MEASURE, ST_SLEEP, ST_START_LOW, ST_WAIT_REL,
		ST_RESP_LOW, ST_RESP_HIGH, ST_BIT_LOW, ST_BIT_HIGH, ST_END_LOW
	} link_state_t;

endpackage

// ==== logic/sample_buffer.sv ====
// Two-entry valid/ready buffer carrying measurement samples
`timescale 1ns/1ps
module sample_buffer
	import sensor_link_pkg::*;
(
	input  wire logic    mclk,
	input  wire logic    rst_b,
	input  wire logic    in_valid,
	output logic         in_ready,
	input  wire sample_t in_data,
	output logic         out_valid,
	input  wire logic    out_ready,
	output sample_t      out_data
);

	typedef struct packed {
		sample_t [1:0] mem;
		logic          wr;
		logic          rd;
		logic    [1:0] cnt;
	} buf_state_t;

	buf_state_t st_r;
	buf_state_t st_nxt;
	logic       push;
	logic       pop;

	assign push      = in_valid && (st_r.cnt != 2'h2);
	assign pop       = out_valid && out_ready;
	assign in_ready  = (st_r.cnt != 2'h2);
	assign out_valid = (st_r.cnt != 2'h0);
	assign out_data  = st_r.mem[st_r.rd];

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wr] = in_data;
			st_nxt.wr           = ~st_r.wr;
		end
		if (pop)
			st_nxt.rd = ~st_r.rd;
		st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	buf_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_r.cnt <= 2'h2) else $error("buffer count overflow");

endmodule

// ==== logic/sensor_link.sv ====
// Sensor end of the single-wire read link
`timescale 1ns/1ps
module sensor_link
	import sensor_link_pkg::*;
#(
	parameter int POWERUP_CYC = CYC_POWERUP,
	parameter int MEAS_CYC    = CYC_MEAS,
	parameter int US_CYC      = CLK_MHZ
)(
	input  wire logic    mclk,
	input  wire logic    rst_b,
	input  wire logic    line_in,
	output logic         line_out,
	output logic         line_oe,
	input  wire sample_t meas_data,
	output logic         meas_req,
	output logic         busy
);

	// ****************************************
	// State and buffer
	// ****************************************
	typedef struct packed {
		link_state_t      state;
		logic [CNT_W-1:0] cnt;
		logic [BIT_W-1:0] bitn;
		logic [39:0]      frame;
		pin_drive_t       pin;
		logic             meas_req;
		logic             busy;
		logic             push;
		sample_t          pdata;
		logic [CNT_W-1:0] held;
	} link_reg_t;

	link_reg_t r;
	link_reg_t nx;
	logic      buf_in_ready;
	logic      buf_out_valid;
	sample_t   buf_out;
	logic      load;
	logic [7:0] chk;

	// Phase lengths in cycles; a bench may shrink the microsecond to keep runs short
	localparam int START_N     = T_START_US * US_CYC;
	localparam int RESP_LOW_N  = T_RESP_LOW_US * US_CYC;
	localparam int RESP_HIGH_N = T_RESP_HIGH_US * US_CYC;
	localparam int BIT_LOW_N   = T_BIT_LOW_US * US_CYC;
	localparam int BIT0_HIGH_N = T_BIT0_HIGH_US * US_CYC;
	localparam int BIT1_HIGH_N = T_BIT1_HIGH_US * US_CYC;
	localparam int END_LOW_N   = T_END_LOW_US * US_CYC;

	sample_buffer u_buf (
		.mclk      (mclk),
		.rst_b     (rst_b),
		.in_valid  (r.push),
		.in_ready  (buf_in_ready),
		.in_data   (r.pdata),
		.out_valid (buf_out_valid),
		.out_ready (load),
		.out_data  (buf_out)
	);

	// check byte from four data bytes
	assign chk = buf_out[31:24] + buf_out[23:16] + buf_out[15:8] + buf_out[7:0];

	assign load = (r.state == ST_WAIT_REL) && line_in && buf_out_valid;

	assign line_out = r.pin.out;
	assign line_oe  = r.pin.oe;
	assign meas_req = r.meas_req;
	assign busy     = r.busy;

	// ****************************************
	// Link sequencer
	// ****************************************
	always_comb begin
		nx          = r;
		nx.push     = 1'b0;
		nx.meas_req = 1'b0;
		nx.cnt      = r.cnt + 1'b1;
		case (r.state)
			ST_POWERUP: begin
				if (r.cnt >= CNT_W'(POWERUP_CYC - 1)) begin
					nx.state = ST_MEASURE;
					nx.cnt   = '0;
				end
			end
			ST_MEASURE: begin
				nx.busy = 1'b1;
				if (r.cnt == '0)
					nx.meas_req = 1'b1;
				if (r.cnt >= CNT_W'(MEAS_CYC - 1) && buf_in_ready) begin
					nx.push  = 1'b1;
					nx.pdata = meas_data;
					nx.state = ST_SLEEP;
					nx.cnt   = '0;
					nx.busy  = 1'b0;
				end
			end
			// pin stays input, only a low wakes
			ST_SLEEP: begin
				nx.pin = '0;
				nx.cnt = '0;
				if (!line_in)
					nx.state = ST_START_LOW;
			end
			ST_START_LOW: begin
				if (line_in) begin
					nx.state = ST_SLEEP;
					nx.cnt   = '0;
				end else if (r.cnt >= CNT_W'(START_N - 1)) begin
					nx.state = ST_WAIT_REL;
					nx.busy  = 1'b1;
				end
			end
			ST_WAIT_REL: begin
				nx.cnt = '0;
				if (load) begin
					nx.frame  = {buf_out, chk};
					nx.state  = ST_RESP_LOW;
					nx.pin.oe = 1'b1;
					nx.pin.out = 1'b0;
				end
			end
			ST_RESP_LOW: begin
				if (r.cnt >= CNT_W'(RESP_LOW_N - 1)) begin
					nx.state   = ST_RESP_HIGH;
					nx.pin.out = 1'b1;
					nx.cnt     = '0;
				end
			end
			ST_RESP_HIGH: begin
				if (r.cnt >= CNT_W'(RESP_HIGH_N - 1)) begin
					nx.state   = ST_BIT_LOW;
					nx.pin.out = 1'b0;
					nx.cnt     = '0;
					nx.bitn    = '0;
				end
			end
			ST_BIT_LOW: begin
				if (r.cnt >= CNT_W'(BIT_LOW_N - 1)) begin
					nx.state   = ST_BIT_HIGH;
					nx.pin.out = 1'b1;
					nx.cnt     = '0;
				end
			end
			ST_BIT_HIGH: begin
				if (r.cnt >= (r.frame[39] ? CNT_W'(BIT1_HIGH_N - 1)
				                          : CNT_W'(BIT0_HIGH_N - 1))) begin
					nx.pin.out = 1'b0;
					nx.cnt     = '0;
					nx.frame   = {r.frame[38:0], 1'b0};
					nx.bitn    = r.bitn + 1'b1;
					nx.state   = (r.bitn == BIT_W'(FRAME_BITS - 1)) ? ST_END_LOW
					                                               : ST_BIT_LOW;
				end
			end
			ST_END_LOW: begin
				if (r.cnt >= CNT_W'(END_LOW_N - 1)) begin
					nx.pin   = '0;
					nx.state = ST_MEASURE;
					nx.cnt   = '0;
				end
			end
			default: begin
				nx.state = ST_SLEEP;
				nx.pin   = '0;
			end
		endcase
		// Age of the present pin level, kept apart from cnt so the checks are independent
		nx.held = (nx.pin != r.pin) ? '0 : r.held + 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			r <= '{state: ST_POWERUP, default: '0};
		else
			r <= nx;
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence resp_low_s;
		r.state == ST_RESP_LOW && line_oe && !line_out;
	endsequence

	sleep_input_a: assert property (@(posedge mclk) disable iff (!rst_b)
		r.state == ST_SLEEP |-> !line_oe) else $error("driving while asleep");

	wake_cause_a: assert property (@(posedge mclk) disable iff (!rst_b)
		r.state == ST_SLEEP && line_in |=> r.state == ST_SLEEP)
		else $error("woke without start pulse");

	resp_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(r.state == ST_RESP_LOW) |-> resp_low_s [*8])
		else $error("response low too short");

	resp_len_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(r.state == ST_RESP_HIGH) |-> $past(r.held) == CNT_W'(RESP_LOW_N - 1))
		else $error("response low length wrong");

	bit_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(r.state == ST_BIT_HIGH) |-> $past(r.held) == CNT_W'(BIT_LOW_N - 1))
		else $error("bit low phase length wrong");

	bit_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$rose(r.state == ST_BIT_HIGH) && r.frame[39]
		|-> (r.state == ST_BIT_HIGH) [*8]) else $error("one bit high short");

	zero_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(r.state == ST_BIT_HIGH) && !$past(r.frame[39])
		|-> $past(r.held) == CNT_W'(BIT0_HIGH_N - 1)) else $error("zero bit width wrong");

	one_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(r.state == ST_BIT_HIGH) && $past(r.frame[39])
		|-> $past(r.held) == CNT_W'(BIT1_HIGH_N - 1)) else $error("one bit width wrong");

	end_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(line_oe) |-> $past(r.state) == ST_END_LOW
		&& $past(r.held) == CNT_W'(END_LOW_N - 1)) else $error("closing low wrong");

	remeasure_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$fell(r.state == ST_END_LOW) |-> ##[1:2] meas_req)
		else $error("no measurement after transfer");

	bit_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
		r.state == ST_BIT_HIGH |-> r.bitn < BIT_W'(FRAME_BITS))
		else $error("bit count overflow");

endmodule

// ==== testbench/host_model.sv ====
// Host side model: start pulse, release, phase timing and bit decoding
`timescale 1ns/1ps
module host_model #(
	parameter int US = 40
)(
	input  wire logic mclk,
	input  wire logic wire_lvl,
	output logic      drv_low
);
	localparam int LIMIT  = 200 * US;
	localparam int THRESH = 48 * US;

	int   w[$];
	logic ok;

	initial drv_low = 1'b0;

	// bounded wait on every level, so a dead line cannot hang the read
	task automatic span(input logic lv, output int n);
		n = 0;
		while (wire_lvl === lv && n < LIMIT) begin
			@(negedge mclk);
			n++;
		end
	endtask

	// drive low, then release to the pull-up
	task automatic pulse(input int lo);
		drv_low = 1'b1;
		repeat (lo) @(negedge mclk);
		drv_low = 1'b0;
	endtask

	// high phase longer than 48 us reads as one
	task automatic read(input int lo, output logic [39:0] f);
		int n;
		w.delete();
		pulse(lo);
		// Let the released level settle before timing starts
		@(posedge mclk);
		span(1'b1, n);
		ok = n < LIMIT;
		for (int i = 0; i < 83; i++) begin
			span(i[0], n);
			w.push_back(n);
			ok &= n > 0 && n < LIMIT;
		end
		for (int k = 0; k < 40; k++)
			f[39-k] = w[3+2*k] > THRESH;
	endtask
endmodule

// ==== testbench/sensor_link_bench.sv ====
// Self-checking bench for the sensor end of the read link
`timescale 1ns/1ps
module sensor_link_bench;
	import sensor_link_pkg::*;
	// Microsecond shrunk to 4 cycles so both full reads fit a short run
	localparam int US = 4;
	logic        mclk, rst_b, line_out, line_oe, meas_req, busy;
	logic        host_low, wire_lvl, oe_seen;
	logic [39:0] f;
	sample_t     meas_data;
	int          failures, compares, cycles, reqs;

	host_model #(.US(US)) host (.mclk(mclk), .wire_lvl(wire_lvl), .drv_low(host_low));
	sensor_link #(.POWERUP_CYC(50), .MEAS_CYC(20), .US_CYC(US)) DUT (
		.mclk(mclk), .rst_b(rst_b), .line_in(wire_lvl), .line_out(line_out),
		.line_oe(line_oe), .meas_data(meas_data), .meas_req(meas_req), .busy(busy)
	);
	// Open-drain wire with pull-up
	assign wire_lvl = !(line_oe === 1'b1 && line_out === 1'b0) && !host_low;

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	always @(negedge mclk) begin
		cycles++;
		if (meas_req === 1'b1) reqs++;
		if (line_oe === 1'b1) oe_seen = 1'b1;
		if (cycles == 60000) begin
			failures++;
			$display("MISMATCH %0t run too long", $time);
			report_and_stop();
		end
	end

	// ******
	// Compare tasks
	// ******
	task automatic check_v(input logic [39:0] got, input logic [39:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_n(input int got, input int exp);
		compares++;
		if (got != exp) begin
			failures++;
			$display("MISMATCH %0t width %0d expected %0d", $time, got, exp);
		end
	endtask

	function automatic logic [39:0] frame_of(sample_t s);
		logic [31:0] b;
		b = s;
		return {b, b[31:24] + b[23:16] + b[15:8] + b[7:0]};
	endfunction

	// ******
	// Scenarios
	// ******
	task automatic t_powerup();
		repeat (75) @(negedge mclk);
		check_n(reqs, 1);
		check_v({39'h0, busy}, 40'h0);
		check_v({39'h0, line_oe}, 40'h0);
		check_v({39'h0, wire_lvl}, 40'h1);
	endtask

	task automatic t_short();
		oe_seen = 1'b0;
		host.pulse(1000);
		repeat (5000) @(negedge mclk);
		check_v({39'h0, oe_seen}, 40'h0);
		check_v({39'h0, busy}, 40'h0);
	endtask

	task automatic t_read(input sample_t s, input int n_req);
		logic [39:0] e;
		e = frame_of(s);
		host.read(1000 * US, f);
		check_v({39'h0, host.ok}, 40'h1);
		check_v(f, e);
		check_n(host.w[0], T_RESP_LOW_US * US);
		check_n(host.w[1], T_RESP_HIGH_US * US);
		for (int k = 0; k < 40; k++) begin
			check_n(host.w[2+2*k], T_BIT_LOW_US * US);
			check_n(host.w[3+2*k], e[39-k] ? T_BIT1_HIGH_US * US : T_BIT0_HIGH_US * US);
		end
		check_n(host.w[82], T_END_LOW_US * US);
		repeat (30) @(negedge mclk);
		check_n(reqs, n_req);
		check_v({38'h0, busy, line_oe}, 40'h0);
	endtask

	task automatic report_and_stop();
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		rst_b = 1'b0;
		oe_seen = 1'b0;
		meas_data = '{humidity: 16'h0292, temp_neg: 1'b0, temp_mag: 15'h010d};
		repeat (20) @(negedge mclk);
		rst_b = 1'b1;
		t_powerup();
		meas_data = '{humidity: 16'h0001, temp_neg: 1'b1, temp_mag: 15'h0065};
		t_short();
		t_read('{humidity: 16'h0292, temp_neg: 1'b0, temp_mag: 15'h010d}, 2);
		t_read('{humidity: 16'h0001, temp_neg: 1'b1, temp_mag: 15'h0065}, 3);
		report_and_stop();
	end
endmodule
